// ### shared/bsc_pkg.sv
// constants and types for the buck standby/sleep configuration registers
// Operation
// R1 - standby voltage code bits 5:0, rw, reset 0
// R2 - standby bit 6 mirrors fused range bit
// R3 - sleep voltage code bits 5:0, rw, reset 0
// R4 - sleep bit 6 mirrors fused range bit
// R5 - mode register bits 3:0 switching mode, rw
// R6 - mode bit 5 sleep state: off or PFM
// R7 - config bit 0 current limit: high/low
// R8 - config bits 3:2 frequency select, reset 0
// R9 - config bits 5:4 phase clock select
// R10 - config bits 7:6 ramp speed select
// R11 - config bit 1 spare, writable, reads back
// R12 - frequency code 00/01/10 gives 1/2/4 MHz
// R13 - all access by I2C byte addresses
// R14 - unused bits read zero, ignore writes
package bsc_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] STANDBY_ADDR = 8'h4b;
  localparam logic [7:0] SLEEP_ADDR = 8'h4c;
  localparam logic [7:0] MODE_ADDR = 8'h4d;
  localparam logic [7:0] CONFIG_ADDR = 8'h4e;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CODE_MSB = 5;
  localparam int RANGE_BIT = 6;
  localparam int MODE_MSB = 3;
  localparam int SLEEP_STATE_BIT = 5;
  localparam int ILIM_BIT = 0;
  localparam int SPARE_BIT = 1;
  localparam int FREQ_LSB = 2;
  localparam int PHASE_LSB = 4;
  localparam int RAMP_LSB = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [5:0] CODE_RST = 6'h00;
  localparam logic [3:0] MODE_RST = 4'h8;
  localparam logic SLEEP_STATE_RST = 1'b0;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************
  // bus device address, arbitrary value
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // ****************************************
  // switching clock timing
  // ****************************************
  localparam longint CLK_HZ = 40000000;
  localparam longint FREQ0_HZ = 1000000;
  localparam longint FREQ1_HZ = 2000000;
  localparam longint FREQ2_HZ = 4000000;
  localparam logic [4:0] HALF0_CYC = 5'(CLK_HZ / (2 * FREQ0_HZ));
  localparam logic [4:0] HALF1_CYC = 5'(CLK_HZ / (2 * FREQ1_HZ));
  localparam logic [4:0] HALF2_CYC = 5'(CLK_HZ / (2 * FREQ2_HZ));
  localparam logic [1:0] FREQ_SEL0 = 2'h0;
  localparam logic [1:0] FREQ_SEL1 = 2'h1;
  localparam logic [1:0] FREQ_SEL2 = 2'h2;

  // ****************************************
  // serial slave states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } bsc_state_type;

endpackage : bsc_pkg

// ### rtl/bsc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module bsc_pin_sync
  import bsc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic pinIn, // raw pin level
  output logic levelOut // filtered level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // ****************************************
  // filter
  // ****************************************
  always_comb begin
    level_nxt = level_r;
    if (s2_r == s3_r) begin
      level_nxt = s2_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign levelOut = level_r;

endmodule : bsc_pin_sync

// ### rtl/bsc_freq_div.sv
// switching clock divider selected by the frequency code
module bsc_freq_div
  import bsc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [1:0] freqSel, // frequency code
  output logic switchClk // converter clock
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic clk_r;
  logic clk_nxt;
  logic [4:0] half;

  // ****************************************
  // half period and count
  // ****************************************
  always_comb begin
    case (freqSel)
      FREQ_SEL0: half = HALF0_CYC; // R12
      FREQ_SEL1: half = HALF1_CYC; // R12
      FREQ_SEL2: half = HALF2_CYC; // R12
      default: half = HALF1_CYC;
    endcase
    cnt_nxt = cnt_r + 5'h01;
    clk_nxt = clk_r;
    if (cnt_nxt >= half) begin
      cnt_nxt = 5'h00;
      clk_nxt = ~clk_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
      clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign switchClk = clk_r;

endmodule : bsc_freq_div

// ### rtl/bsc_regs.sv
// buck standby/sleep configuration registers behind an I2C slave
module bsc_regs
  import bsc_pkg::*;
(
  input wire logic clk, // system clock 40 MHz
  input wire logic rst, // async reset, high
  input wire logic sclIn, // bus clock pin
  input wire logic sdaIn, // bus data pin level
  output logic sdaOut, // data drive value, always low
  output logic sdaOe, // data drive enable
  input wire logic rangeFuse, // fused normal-mode range bit
  output logic [6:0] standbyVoltageCode, // standby code with range
  output logic [6:0] sleepVoltageCode, // sleep code with range
  output logic [3:0] switchModeSelect, // normal switching mode
  output logic sleepStateSelect, // 0 off, 1 PFM in sleep
  output logic currentLimitSelect, // 0 high, 1 low limit
  output logic [1:0] switchFreqSelect, // frequency code
  output logic [1:0] phaseClockSelect, // phase clock code
  output logic [1:0] rampSpeedSelect, // ramp speed code
  output logic switchClk // converter switching clock
);

  logic sclF;
  logic sdaF;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  bsc_state_type state_r;
  bsc_state_type state_nxt;
  logic [2:0] bitCnt_r;
  logic [2:0] bitCnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic done_r;
  logic done_nxt;
  logic readMode_r;
  logic readMode_nxt;
  logic more_r;
  logic more_nxt;
  logic sdaOe_r;
  logic sdaOe_nxt;

  logic [5:0] stbyCode_r;
  logic [5:0] stbyCode_nxt;
  logic [5:0] sleepCode_r;
  logic [5:0] sleepCode_nxt;
  logic [3:0] mode_r;
  logic [3:0] mode_nxt;
  logic sleepState_r;
  logic sleepState_nxt;
  logic [7:0] conf_r;
  logic [7:0] conf_nxt;
  logic range_r;

  // ****************************************
  // pin conditioning
  // ****************************************
  bsc_pin_sync u_scl_sync (
    .clk(clk),
    .rst(rst),
    .pinIn(sclIn),
    .levelOut(sclF)
  );

  bsc_pin_sync u_sda_sync (
    .clk(clk),
    .rst(rst),
    .pinIn(sdaIn),
    .levelOut(sdaF)
  );

  assign sclRise = sclF & ~sclPrev_r;
  assign sclFall = ~sclF & sclPrev_r;
  assign startSeen = sclF & sclPrev_r & sdaPrev_r & ~sdaF;
  assign stopSeen = sclF & sclPrev_r & ~sdaPrev_r & sdaF;

  // ****************************************
  // read decode
  // ****************************************
  function automatic logic [7:0] readByte(
    input logic [7:0] addr,
    input logic [5:0] stby,
    input logic [5:0] slp,
    input logic [3:0] md,
    input logic ss,
    input logic [7:0] cf,
    input logic rng
  );
    logic [7:0] v;
    v = READ_ZERO; // R14
    case (addr)
      STANDBY_ADDR: begin
        v[CODE_MSB:0] = stby; // R1
        v[RANGE_BIT] = rng; // R2
      end
      SLEEP_ADDR: begin
        v[CODE_MSB:0] = slp; // R3
        v[RANGE_BIT] = rng; // R4
      end
      MODE_ADDR: begin
        v[MODE_MSB:0] = md; // R5
        v[SLEEP_STATE_BIT] = ss; // R6
      end
      CONFIG_ADDR: v = cf; // R11
      default: v = READ_ZERO; // R14
    endcase
    return v;
  endfunction : readByte

  // ****************************************
  // slave sequencer and register writes
  // ****************************************
  always_comb begin
    logic [7:0] rd;
    logic [7:0] inByte;
    rd = readByte(ptr_r, stbyCode_r, sleepCode_r, mode_r, sleepState_r,
      conf_r, range_r);
    inByte = {shift_r[6:0], sdaF};
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    done_nxt = done_r;
    readMode_nxt = readMode_r;
    more_nxt = more_r;
    sdaOe_nxt = sdaOe_r;
    stbyCode_nxt = stbyCode_r;
    sleepCode_nxt = sleepCode_r;
    mode_nxt = mode_r;
    sleepState_nxt = sleepState_r;
    conf_nxt = conf_r;
    if (startSeen) begin
      state_nxt = ST_ADDR;
      bitCnt_nxt = 3'h0;
      done_nxt = 1'b0;
      sdaOe_nxt = 1'b0;
    end else if (stopSeen) begin
      state_nxt = ST_IDLE;
      sdaOe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sdaOe_nxt = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise && !done_r) begin
            shift_nxt = inByte;
            bitCnt_nxt = bitCnt_r + 3'h1;
            done_nxt = (bitCnt_r == 3'h7);
          end else if (sclFall && done_r) begin
            done_nxt = 1'b0;
            case (state_r)
              ST_ADDR: begin
                readMode_nxt = shift_r[0];
                if (shift_r[7:1] == DEV_ADDR) begin
                  sdaOe_nxt = 1'b1;
                  state_nxt = ST_ADDR_ACK;
                end else begin
                  state_nxt = ST_IDLE;
                end
              end
              ST_PTR: begin
                ptr_nxt = shift_r; // R13
                sdaOe_nxt = 1'b1;
                state_nxt = ST_PTR_ACK;
              end
              default: begin
                // unmapped or read-only bits ignore the write
                case (ptr_r)
                  STANDBY_ADDR: stbyCode_nxt = shift_r[CODE_MSB:0]; // R1
                  SLEEP_ADDR: sleepCode_nxt = shift_r[CODE_MSB:0]; // R3
                  MODE_ADDR: begin
                    mode_nxt = shift_r[MODE_MSB:0]; // R5
                    sleepState_nxt = shift_r[SLEEP_STATE_BIT]; // R6
                  end
                  CONFIG_ADDR: conf_nxt = shift_r; // R7
                  default: conf_nxt = conf_r; // R14
                endcase
                ptr_nxt = ptr_r + 8'h01;
                sdaOe_nxt = 1'b1;
                state_nxt = ST_WDATA_ACK;
              end
            endcase
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          if (sclFall) begin
            bitCnt_nxt = 3'h0;
            if (state_r == ST_ADDR_ACK && readMode_r) begin
              shift_nxt = rd;
              ptr_nxt = ptr_r + 8'h01;
              sdaOe_nxt = ~rd[7];
              state_nxt = ST_RDATA;
            end else begin
              sdaOe_nxt = 1'b0;
              state_nxt = (state_r == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (sclRise) begin
            bitCnt_nxt = bitCnt_r + 3'h1;
            done_nxt = (bitCnt_r == 3'h7);
          end else if (sclFall) begin
            if (done_r) begin
              done_nxt = 1'b0;
              sdaOe_nxt = 1'b0;
              state_nxt = ST_RDATA_ACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              sdaOe_nxt = ~shift_r[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (sclRise) begin
            more_nxt = ~sdaF;
          end else if (sclFall) begin
            bitCnt_nxt = 3'h0;
            if (more_r) begin
              shift_nxt = rd;
              ptr_nxt = ptr_r + 8'h01;
              sdaOe_nxt = ~rd[7];
              state_nxt = ST_RDATA;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          sdaOe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      state_r <= ST_IDLE;
      bitCnt_r <= 3'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      done_r <= 1'b0;
      readMode_r <= 1'b0;
      more_r <= 1'b0;
      sdaOe_r <= 1'b0;
      stbyCode_r <= CODE_RST;
      sleepCode_r <= CODE_RST;
      mode_r <= MODE_RST;
      sleepState_r <= SLEEP_STATE_RST;
      conf_r <= CONFIG_RST;
      range_r <= 1'b0;
    end else begin
      sclPrev_r <= sclF;
      sdaPrev_r <= sdaF;
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      done_r <= done_nxt;
      readMode_r <= readMode_nxt;
      more_r <= more_nxt;
      sdaOe_r <= sdaOe_nxt;
      stbyCode_r <= stbyCode_nxt;
      sleepCode_r <= sleepCode_nxt;
      mode_r <= mode_nxt;
      sleepState_r <= sleepState_nxt;
      conf_r <= conf_nxt;
      range_r <= rangeFuse; // R2
    end
  end

  // ****************************************
  // converter clock
  // ****************************************
  bsc_freq_div u_freq_div (
    .clk(clk),
    .rst(rst),
    .freqSel(conf_r[FREQ_LSB +: 2]),
    .switchClk(switchClk)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_r;
  assign standbyVoltageCode = {range_r, stbyCode_r}; // R2
  assign sleepVoltageCode = {range_r, sleepCode_r}; // R4
  assign switchModeSelect = mode_r;
  assign sleepStateSelect = sleepState_r;
  assign currentLimitSelect = conf_r[ILIM_BIT]; // R7
  assign switchFreqSelect = conf_r[FREQ_LSB +: 2]; // R8
  assign phaseClockSelect = conf_r[PHASE_LSB +: 2]; // R9
  assign rampSpeedSelect = conf_r[RAMP_LSB +: 2]; // R10

endmodule : bsc_regs

// ### test/bsc_regs_sva.sv
// port checks for the configuration register block
module bsc_regs_sva
  import bsc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic sclIn, // bus clock
  input wire logic sdaIn, // bus data
  input wire logic sdaOut, // drive value
  input wire logic sdaOe, // drive enable
  input wire logic rangeFuse, // range bit
  input wire logic [6:0] standbyVoltageCode, // standby
  input wire logic [6:0] sleepVoltageCode, // sleep
  input wire logic [3:0] switchModeSelect, // mode
  input wire logic sleepStateSelect, // sleep state
  input wire logic currentLimitSelect, // limit
  input wire logic [1:0] switchFreqSelect, // frequency
  input wire logic [1:0] phaseClockSelect, // phase
  input wire logic [1:0] rampSpeedSelect, // ramp
  input wire logic switchClk // converter clock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // half period measurement
  // ****************************************
  logic [5:0] cnt_r, cnt_nxt, age_r, age_nxt, halfExp;
  logic clkPrev_r;
  logic [1:0] selPrev_r;
  always_comb begin
    cnt_nxt = (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h01;
    if (switchClk != clkPrev_r) cnt_nxt = 6'h01;
    age_nxt = (age_r == 6'h3f) ? age_r : age_r + 6'h01;
    if (switchFreqSelect != selPrev_r) age_nxt = 6'h00;
    halfExp = (switchFreqSelect == FREQ_SEL0) ? 6'(HALF0_CYC) :
              (switchFreqSelect == FREQ_SEL2) ? 6'(HALF2_CYC) : 6'(HALF1_CYC);
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 6'h00;
      age_r <= 6'h00;
      clkPrev_r <= 1'b0;
      selPrev_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
      age_r <= age_nxt;
      clkPrev_r <= switchClk;
      selPrev_r <= switchFreqSelect;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  property p_range_stby;
    !$past(rst) |-> standbyVoltageCode[6] == $past(rangeFuse);
  endproperty
  a_range_stby: assert property (p_range_stby)
    else $error("standby range bit not the fuse");
  property p_range_sleep;
    !$past(rst) |-> sleepVoltageCode[6] == $past(rangeFuse);
  endproperty
  a_range_sleep: assert property (p_range_sleep)
    else $error("sleep range bit not the fuse");
  property p_stby_quiet;
    $changed(standbyVoltageCode[5:0]) |-> !sclIn;
  endproperty
  a_stby_quiet: assert property (p_stby_quiet)
    else $error("standby code moved with bus clock high");
  property p_sleep_quiet;
    $changed(sleepVoltageCode[5:0]) |-> !sclIn;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("sleep code moved with bus clock high");
  property p_mode_quiet;
    $changed({sleepStateSelect, switchModeSelect}) |-> !sclIn;
  endproperty
  a_mode_quiet: assert property (p_mode_quiet)
    else $error("mode moved with bus clock high");
  property p_cfg_quiet;
    $changed({rampSpeedSelect, phaseClockSelect, switchFreqSelect,
              currentLimitSelect}) |-> !sclIn;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("config moved with bus clock high");
  property p_sda_edge;
    $changed(sdaOe) |-> !sclIn && !sdaOut;
  endproperty
  a_sda_edge: assert property (p_sda_edge)
    else $error("data drive changed with bus clock high");
  property p_ack_hold;
    $rose(sdaOe) |=> sdaOe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data drive pulse too short");
  property p_half;
    (switchClk != clkPrev_r) && (age_r > 6'd45) |-> cnt_r == halfExp;
  endproperty
  a_half: assert property (p_half)
    else $error("switching half period wrong");
  property p_half_max;
    cnt_r != 6'h3f;
  endproperty
  a_half_max: assert property (p_half_max)
    else $error("switching clock stuck");
  c_ack: cover property ($rose(sdaOe));
  c_fast: cover property (switchFreqSelect == FREQ_SEL2 && $rose(switchClk));
  c_pfm: cover property ($rose(sleepStateSelect));
endmodule : bsc_regs_sva

bind bsc_regs bsc_regs_sva u_sva (.clk, .rst, .sclIn, .sdaIn, .sdaOut,
  .sdaOe, .rangeFuse, .standbyVoltageCode, .sleepVoltageCode,
  .switchModeSelect, .sleepStateSelect, .currentLimitSelect,
  .switchFreqSelect, .phaseClockSelect, .rampSpeedSelect, .switchClk);

// ### test/bsc_host_model.sv
// behavioural two-wire bus master for the register block
module bsc_host_model
  import bsc_pkg::*;
#(parameter int QTR = 6)
(
  input wire logic clk, // clock
  output logic scl, // bus clock drive
  output logic sdaLow, // pulls data low
  input wire logic sda // resolved data wire
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic wq;
    repeat (QTR) @(posedge clk);
    #1;
  endtask : wq
  task automatic bitx(input logic b, output logic r);
    sdaLow = !b;
    wq();
    scl = 1'b1;
    wq();
    wq();
    r = sda;
    scl = 1'b0;
    wq();
  endtask : bitx
  task automatic start;
    sdaLow = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sdaLow = 1'b1;
    wq();
    scl = 1'b0;
    wq();
  endtask : start
  task automatic stop;
    sdaLow = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sdaLow = 1'b0;
    wq();
  endtask : stop
  // ninth bit always released: reads ack, or sends nack
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, r);
    ack = !r;
  endtask : xbyte
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d,
                          input logic [6:0] dev, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xbyte({dev, 1'b0}, q, a0);
    xbyte(a, q, a1);
    xbyte(d, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : writeReg
  task automatic readReg(input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    xbyte({DEV_ADDR, 1'b0}, q, a0);
    xbyte(a, q, a1);
    start();
    xbyte({DEV_ADDR, 1'b1}, q, a2);
    xbyte(8'hff, d, a3);
    stop();
    ok = a0 & a1 & a2 & !a3;
  endtask : readReg
  // two data bytes in one frame, pointer steps between them
  task automatic writePair(input logic [7:0] a, input logic [7:0] d0,
                           input logic [7:0] d1, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    xbyte({DEV_ADDR, 1'b0}, q, a0);
    xbyte(a, q, a1);
    xbyte(d0, q, a2);
    xbyte(d1, q, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask : writePair
  // two-byte read: master acks the first byte, nacks the last
  task automatic readPair(input logic [7:0] a, output logic [7:0] d0,
                          output logic [7:0] d1, output logic ok);
    logic [7:0] q;
    logic r;
    logic a0, a1, a2, a3;
    start();
    xbyte({DEV_ADDR, 1'b0}, q, a0);
    xbyte(a, q, a1);
    start();
    xbyte({DEV_ADDR, 1'b1}, q, a2);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d0[i]);
    bitx(1'b0, r);
    xbyte(8'hff, d1, a3);
    stop();
    ok = a0 & a1 & a2 & !a3;
  endtask : readPair
endmodule : bsc_host_model

// ### test/tb_top.sv
// self-checking bench for the configuration register block
module tb_top
  import bsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, rangeFuse, scl, hostLow, sdaOut, sdaOe, ok;
  logic [6:0] stby, slp;
  logic [3:0] mode;
  logic sst, ilim, swClk;
  logic [1:0] freq, phase, ramp;
  logic [7:0] rdA, rdB;
  wire logic sda = !((sdaOe && !sdaOut) || hostLow);
  int n_errors = 0;
  int tests_run = 0;
  bsc_regs uut (.clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .rangeFuse(rangeFuse),
    .standbyVoltageCode(stby), .sleepVoltageCode(slp),
    .switchModeSelect(mode), .sleepStateSelect(sst),
    .currentLimitSelect(ilim), .switchFreqSelect(freq),
    .phaseClockSelect(phase), .rampSpeedSelect(ramp), .switchClk(swClk));
  bsc_host_model u_host (.clk(clk), .scl(scl), .sdaLow(hostLow), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.writeReg(a, d, DEV_ADDR, ok);
    check({7'h00, ok}, 8'h01, "write ack");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.readReg(a, d, ok);
    check({7'h00, ok}, 8'h01, "read ack");
    check(d, exp, "read data");
  endtask : rd
  task automatic ports(input logic [7:0] s, input logic [7:0] m,
                       input logic [7:0] c);
    check({1'b0, stby}, s, "standby port");
    check({2'h0, sst, 1'b0, mode}, m, "mode port");
    check({ramp, phase, freq, 1'b0, ilim}, c & 8'hfd, "config port");
  endtask : ports
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #2000000;
    n_errors++;
    $display("unexpected at %0t: watchdog", $time);
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    rangeFuse = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    ports(8'h40, {4'h0, MODE_RST}, CONFIG_RST);
    check({1'b0, slp}, 8'h40, "sleep port");
    rd(STANDBY_ADDR, 8'h40);
    rd(SLEEP_ADDR, 8'h40);
    rd(MODE_ADDR, {4'h0, MODE_RST});
    rd(CONFIG_ADDR, CONFIG_RST);
    wr(STANDBY_ADDR, 8'hbf);
    wr(SLEEP_ADDR, 8'hd5);
    wr(MODE_ADDR, 8'hff);
    wr(CONFIG_ADDR, 8'hfe);
    ports(8'h7f, 8'h2f, 8'hfe);
    check({1'b0, slp}, 8'h55, "sleep port");
    rd(STANDBY_ADDR, 8'h7f);
    rd(SLEEP_ADDR, 8'h55);
    rd(MODE_ADDR, 8'h2f);
    rd(CONFIG_ADDR, 8'hfe);
    wr(MODE_ADDR, 8'h00);
    rd(MODE_ADDR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(CONFIG_ADDR, 8'(i * 4 + 1));
      repeat (200) @(posedge clk);
      #1;
      ports(8'h7f, 8'h00, 8'(i * 4 + 1));
      rd(CONFIG_ADDR, 8'(i * 4 + 1));
    end
    wr(8'h4f, 8'hff);
    rd(8'h4f, READ_ZERO);
    u_host.writeReg(CONFIG_ADDR, 8'h00, DEV_ADDR ^ 7'h01, ok);
    check({7'h00, ok}, 8'h00, "foreign address acked");
    rd(CONFIG_ADDR, 8'h09);
    rangeFuse = 1'b0;
    rd(STANDBY_ADDR, 8'h3f);
    rd(SLEEP_ADDR, 8'h15);
    u_host.writePair(STANDBY_ADDR, 8'h2a, 8'h0c, ok);
    check({7'h00, ok}, 8'h01, "pair write ack");
    check({1'b0, slp}, 8'h0c, "sleep port");
    u_host.readPair(STANDBY_ADDR, rdA, rdB, ok);
    check({7'h00, ok}, 8'h01, "pair read ack");
    check(rdA, 8'h2a, "pair first byte");
    check(rdB, 8'h0c, "pair second byte");
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    ports(8'h00, {4'h0, MODE_RST}, CONFIG_RST);
    rd(CONFIG_ADDR, CONFIG_RST);
    end_of_test();
  end
endmodule : tb_top
